// File: logic/bfs_scheme.v
`timescale 1ns/1ps
`include "bfs_map.vh"

module bfs_scheme #(
  parameter DW          = `BFS_DELAY_W,
  parameter MW          = `BFS_MAG_W,
  parameter TICK_CYCLES = `BFS_TICK_CYCLES
) (
  input  wire          clock,
  input  wire          rstn,
  input  wire          ce,
  input  wire          block,
  input  wire          pole_mode_select,
  input  wire          initiate_current_supervision_enable,
  input  wire          seal_in_enable,
  input  wire          three_pole_initiate_input,
  input  wire [2:0]    pole_initiate_input,
  input  wire          early_path_enable,
  input  wire          main_path_enable,
  input  wire          slow_path_enable,
  input  wire [DW-1:0] early_path_delay,
  input  wire [DW-1:0] main_path_delay,
  input  wire [DW-1:0] slow_path_delay,
  input  wire [DW-1:0] loset_delay,
  input  wire [DW-1:0] zone_trip_hold_time,
  input  wire [MW-1:0] phase_supervision_threshold,
  input  wire [MW-1:0] neutral_supervision_threshold,
  input  wire [MW-1:0] phase_hiset_threshold,
  input  wire [MW-1:0] neutral_hiset_threshold,
  input  wire [MW-1:0] phase_loset_threshold,
  input  wire [MW-1:0] neutral_loset_threshold,
  input  wire [MW-1:0] phase_a_magnitude,
  input  wire [MW-1:0] phase_b_magnitude,
  input  wire [MW-1:0] phase_c_magnitude,
  input  wire [MW-1:0] neutral_magnitude,
  input  wire [2:0]    early_aux_contact_input,
  input  wire [2:0]    normal_aux_contact_input,
  input  wire          out_of_service_input,
  input  wire          target_reset,
  output reg  [2:0]    retrip_q,
  output reg  [2:0]    initiated_q,
  output reg  [2:0]    early_op_q,
  output reg  [2:0]    main_op_q,
  output reg  [2:0]    slow_op_q,
  output reg  [2:0]    hiset_active_q,
  output reg  [2:0]    loset_active_q,
  output reg           zone_trip_output,
  output reg           failed_target_q,
  output reg           trip_led_q,
  output reg  [2:0]    phase_led_q
);

  localparam integer TICK_LAST = TICK_CYCLES - 1;
  localparam [1:0] ZT_IDLE = `BFS_ZT_IDLE;
  localparam [1:0] ZT_TRIP = `BFS_ZT_TRIP;
  localparam [1:0] ZT_HOLD = `BFS_ZT_HOLD;

  wire                     single_pole;
  wire [2:0]               early_aux;
  wire [2:0]               normal_aux;
  wire                     out_of_service;
  wire [MW-1:0]            phase_mag [0:2];
  wire [2:0]               pole_init;
  wire [2:0]               sup_ok;
  wire [2:0]               accept;
  wire [2:0]               active;
  wire [2:0]               early_done;
  wire [2:0]               main_done;
  wire [2:0]               slow_done;
  wire [2:0]               loset_done;
  wire [2:0]               hiset_on;
  wire [2:0]               fault_cur;
  wire [2:0]               early_op;
  wire [2:0]               main_op;
  wire [2:0]               slow_op;
  wire [2:0]               pole_fail;
  wire                     any_fail;
  reg  [2:0]               seal_q;
  reg  [2:0]               seal_d;
  reg  [`BFS_PRESCALE_W-1:0] pre_q;
  reg                      tick_q;
  reg  [1:0]               zt_state_q;
  reg  [1:0]               zt_state_d;
  reg  [DW:0]              hold_cnt_q;
  reg  [DW:0]              hold_cnt_d;

  assign single_pole  = (pole_mode_select == `BFS_MODE_1P);
  assign phase_mag[0] = phase_a_magnitude;
  assign phase_mag[1] = phase_b_magnitude;
  assign phase_mag[2] = phase_c_magnitude;

  // Contacts come from the yard and need synchronising
  bfs_sync #(
    .W (7)
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .d     ({out_of_service_input, normal_aux_contact_input,
             early_aux_contact_input}),
    .q     ({out_of_service, normal_aux, early_aux})
  );

  // Shared millisecond tick for every timer
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      pre_q  <= `BFS_CNT_RST;
      tick_q <= 1'b0;
    end
    else if (ce)
    begin
      if (pre_q == TICK_LAST[`BFS_PRESCALE_W-1:0])
      begin
        pre_q  <= `BFS_CNT_RST;
        tick_q <= 1'b1;
      end
      else
      begin
        pre_q  <= pre_q + 16'h0001;
        tick_q <= 1'b0;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < `BFS_POLES; p = p + 1)
    begin : g_pole
      wire ph_sup;
      wire n_sup;
      wire hi_det;
      wire lo_det;

      // In three-pole mode every pole follows the common initiate
      assign pole_init[p] = ~block & (single_pole ? pole_initiate_input[p]
                                                  : three_pole_initiate_input);

      // Supervision: phase always, neutral only in three-pole mode
      assign ph_sup    = phase_mag[p] > phase_supervision_threshold;
      assign n_sup     = ~single_pole &
                         (neutral_magnitude > neutral_supervision_threshold);
      assign sup_ok[p] = ph_sup | n_sup;

      // Current-supervised initiate is optional
      assign accept[p] = pole_init[p] &
                         (~initiate_current_supervision_enable | sup_ok[p]);
      assign active[p] = accept[p] | seal_q[p];

      // Three delayed paths, each run only while its enable is set
      bfs_delay_timer #(
        .DW (DW)
      ) u_early (
        .clock  (clock),
        .rstn   (rstn),
        .ce     (ce),
        .run    (active[p] & early_path_enable),
        .tick   (tick_q),
        .delay  (early_path_delay),
        .done_q (early_done[p])
      );

      bfs_delay_timer #(
        .DW (DW)
      ) u_main (
        .clock  (clock),
        .rstn   (rstn),
        .ce     (ce),
        .run    (active[p] & main_path_enable),
        .tick   (tick_q),
        .delay  (main_path_delay),
        .done_q (main_done[p])
      );

      bfs_delay_timer #(
        .DW (DW)
      ) u_slow (
        .clock  (clock),
        .rstn   (rstn),
        .ce     (ce),
        .run    (active[p] & slow_path_enable & ~out_of_service),
        .tick   (tick_q),
        .delay  (slow_path_delay),
        .done_q (slow_done[p])
      );

      // Hiset enabled on early or main timeout; loset follows its delay
      assign hiset_on[p] = early_done[p] | main_done[p];

      bfs_delay_timer #(
        .DW (DW)
      ) u_loset (
        .clock  (clock),
        .rstn   (rstn),
        .ce     (ce),
        .run    (hiset_on[p]),
        .tick   (tick_q),
        .delay  (loset_delay),
        .done_q (loset_done[p])
      );

      // Detectors only count once the failure delay is over, so
      // their own reset speed does not matter
      assign hi_det = hiset_on[p] &
                      ((phase_mag[p] > phase_hiset_threshold) |
                       (~single_pole &
                        (neutral_magnitude > neutral_hiset_threshold)));
      assign lo_det = loset_done[p] &
                      ((phase_mag[p] > phase_loset_threshold) |
                       (~single_pole &
                        (neutral_magnitude > neutral_loset_threshold)));
      assign fault_cur[p] = hi_det | lo_det;

      // Early path: contact still closed and current flowing
      assign early_op[p] = early_path_enable & early_done[p] &
                           early_aux[p] & fault_cur[p];
      // Main path: current alone, contacts not looked at
      assign main_op[p]  = main_path_enable & main_done[p] & fault_cur[p];
      // Slow path: contact and service switch, no current check
      assign slow_op[p]  = slow_path_enable & slow_done[p] &
                           normal_aux[p] & ~out_of_service;
      assign pole_fail[p] = early_op[p] | main_op[p] | slow_op[p];
    end
  endgenerate

  // In three-pole mode only pole A contacts matter
  assign any_fail = single_pole ? |pole_fail : pole_fail[0];

  // Seal-in holds only while current stays above supervision
  always @*
  begin
    seal_d = seal_q;
    if (block)
      seal_d = `BFS_POLE_RST;
    else if (!seal_in_enable)
      seal_d = `BFS_POLE_RST;
    else
      seal_d = (seal_q | accept) & sup_ok;
  end

  always @(posedge clock)
  begin
    if (!rstn)
      seal_q <= `BFS_POLE_RST;
    else if (ce)
      seal_q <= seal_d;
  end

  // Status and re-trip outputs, all registered
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      retrip_q       <= `BFS_POLE_RST;
      initiated_q    <= `BFS_POLE_RST;
      early_op_q     <= `BFS_POLE_RST;
      main_op_q      <= `BFS_POLE_RST;
      slow_op_q      <= `BFS_POLE_RST;
      hiset_active_q <= `BFS_POLE_RST;
      loset_active_q <= `BFS_POLE_RST;
    end
    else if (ce)
    begin
      if (block)
      begin
        retrip_q       <= `BFS_POLE_RST;
        initiated_q    <= `BFS_POLE_RST;
        early_op_q     <= `BFS_POLE_RST;
        main_op_q      <= `BFS_POLE_RST;
        slow_op_q      <= `BFS_POLE_RST;
        hiset_active_q <= `BFS_POLE_RST;
        loset_active_q <= `BFS_POLE_RST;
      end
      else
      begin
        retrip_q       <= active;
        initiated_q    <= active;
        early_op_q     <= early_op;
        main_op_q      <= main_op;
        slow_op_q      <= slow_op;
        hiset_active_q <= hiset_on;
        // Loset status never outlives hiset, even for the timer's clear cycle
        loset_active_q <= loset_done & hiset_on;
      end
    end
  end

  // Zone trip: on while failure persists, then held for the dropout time
  always @*
  begin
    zt_state_d = zt_state_q;
    hold_cnt_d = hold_cnt_q;
    case (zt_state_q)
      ZT_IDLE:
      begin
        if (any_fail)
          zt_state_d = ZT_TRIP;
      end
      ZT_TRIP:
      begin
        hold_cnt_d = {(DW+1){1'b0}};
        if (!any_fail)
          zt_state_d = ZT_HOLD;
      end
      ZT_HOLD:
      begin
        if (any_fail)
          zt_state_d = ZT_TRIP;
        else if (hold_cnt_q >= {1'b0, zone_trip_hold_time})
          zt_state_d = ZT_IDLE;
        else if (tick_q)
          hold_cnt_d = hold_cnt_q + {{DW{1'b0}}, 1'b1};
      end
      default:
      begin
        zt_state_d = ZT_IDLE;
        hold_cnt_d = {(DW+1){1'b0}};
      end
    endcase
    if (block)
    begin
      zt_state_d = ZT_IDLE;
      hold_cnt_d = {(DW+1){1'b0}};
    end
  end

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      zt_state_q       <= ZT_IDLE;
      hold_cnt_q       <= {(DW+1){1'b0}};
      zone_trip_output <= 1'b0;
    end
    else if (ce)
    begin
      zt_state_q <= zt_state_d;
      hold_cnt_q <= hold_cnt_d;
      // One trip output for all poles, so single-pole still trips three
      zone_trip_output <= (zt_state_d != ZT_IDLE);
    end
  end

  // Targets stick until reset; a new failure beats a reset in the same cycle
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      failed_target_q <= 1'b0;
      trip_led_q      <= 1'b0;
      phase_led_q     <= `BFS_POLE_RST;
    end
    else if (ce)
    begin
      if (block)
      begin
        failed_target_q <= 1'b0;
        trip_led_q      <= 1'b0;
        phase_led_q     <= `BFS_POLE_RST;
      end
      else
      begin
        failed_target_q <= any_fail | (failed_target_q & ~target_reset);
        trip_led_q      <= any_fail | (trip_led_q & ~target_reset);
        // Phase indication only means something per pole
        phase_led_q     <= (single_pole ? pole_fail : `BFS_POLE_RST) |
                           (phase_led_q & {3{~target_reset}});
      end
    end
  end

endmodule // bfs_scheme

// File: logic/bfs_map.vh
`ifndef BFS_MAP_VH
`define BFS_MAP_VH

// Clock rate and the millisecond time base
`define BFS_CLK_HZ        40000000
`define BFS_TICK_MS       1
`define BFS_MS_PER_S      1000
`define BFS_TICK_CYCLES   (`BFS_CLK_HZ / `BFS_MS_PER_S * `BFS_TICK_MS)

// Widths
`define BFS_DELAY_W       16
`define BFS_MAG_W         16
`define BFS_POLES         3
`define BFS_PRESCALE_W    16

// Pole mode encoding
`define BFS_MODE_3P       1'b0
`define BFS_MODE_1P       1'b1

// Reset values
`define BFS_CNT_RST       16'h0000
`define BFS_POLE_RST      3'h0

// Zone trip hold state codes
`define BFS_ZT_IDLE       2'h0
`define BFS_ZT_TRIP       2'h1
`define BFS_ZT_HOLD       2'h2

`endif

// File: logic/bfs_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for contact inputs, one chain per bit
module bfs_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rstn,
  input  wire         ce,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_q;
      reg sync_q;
      // First stage feeds only the second
      always @(posedge clock)
      begin
        if (!rstn)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else if (ce)
        begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule // bfs_sync

// File: logic/bfs_delay_timer.v
`timescale 1ns/1ps
// Pickup timer in millisecond ticks; done holds while run stays high
module bfs_delay_timer #(
  parameter DW = 16
) (
  input  wire          clock,
  input  wire          rstn,
  input  wire          ce,
  input  wire          run,
  input  wire          tick,
  input  wire [DW-1:0] delay,
  output reg           done_q
);

  reg [DW:0] cnt_q;

  // Counting restarts whenever run drops; first tick may be early by
  // up to one millisecond because the tick base is shared
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      cnt_q  <= {(DW+1){1'b0}};
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        cnt_q  <= {(DW+1){1'b0}};
        done_q <= 1'b0;
      end
      else
      begin
        if (tick && (cnt_q < {1'b0, delay}))
          cnt_q <= cnt_q + {{DW{1'b0}}, 1'b1};
        done_q <= (cnt_q >= {1'b0, delay});
      end
    end
  end

endmodule // bfs_delay_timer

// File: sim/bfs_breaker.sv
`timescale 1ns/1ps
// Protected breaker and current source facing the scheme
module bfs_breaker #(
  parameter OPEN_CYC = 4
) (
  input  wire        clock,
  input  wire        trip,
  input  wire [1:0]  mode,
  input  wire [15:0] level,
  output wire [2:0]  aux,
  output wire [15:0] mag
);
  reg [7:0] cnt_q;

  // Contacts part OPEN_CYC cycles after trip; recloses once trip drops
  always @(posedge clock)
  begin
    if (!trip)
      cnt_q <= 8'h00;
    else if (cnt_q != OPEN_CYC)
      cnt_q <= cnt_q + 8'h01;
  end

  // Mode 1 stuck shut; mode 2 parts contacts but keeps arcing current
  assign aux = (cnt_q == OPEN_CYC && mode != 2'h1) ? 3'h0 : 3'h7;
  assign mag = (cnt_q == OPEN_CYC && mode == 2'h0) ? 16'h0000 : level;
endmodule // bfs_breaker

// File: sim/bfs_checker.sv
`timescale 1ns/1ps
// Port-level checks on the breaker failure scheme
module bfs_checker (
  input wire        clock,
  input wire        rstn,
  input wire        ce,
  input wire        block,
  input wire        pole_mode_select,
  input wire        initiate_current_supervision_enable,
  input wire        three_pole_initiate_input,
  input wire        early_path_enable,
  input wire        main_path_enable,
  input wire        slow_path_enable,
  input wire        out_of_service_input,
  input wire [15:0] phase_supervision_threshold,
  input wire [15:0] neutral_supervision_threshold,
  input wire [15:0] phase_a_magnitude,
  input wire [15:0] phase_b_magnitude,
  input wire [15:0] phase_c_magnitude,
  input wire [15:0] neutral_magnitude,
  input wire [2:0]  retrip_q,
  input wire [2:0]  early_op_q,
  input wire [2:0]  main_op_q,
  input wire [2:0]  slow_op_q,
  input wire [2:0]  hiset_active_q,
  input wire [2:0]  loset_active_q,
  input wire        zone_trip_output,
  input wire        failed_target_q,
  input wire        trip_led_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Helper terms: any path operating, all currents below supervision
  wire ops_any = |{early_op_q, main_op_q, slow_op_q};
  wire cur_low = phase_a_magnitude <= phase_supervision_threshold
              && phase_b_magnitude <= phase_supervision_threshold
              && phase_c_magnitude <= phase_supervision_threshold
              && neutral_magnitude <= neutral_supervision_threshold;

  // Long enough to pass the two-flop synchroniser and timer reset
  sequence s_oos_held;
    (ce && out_of_service_input) [*6];
  endsequence
  sequence s_fail_rise;
    $rose(zone_trip_output);
  endsequence

  property p_retrip_now;
    ce && !block && !pole_mode_select && !initiate_current_supervision_enable
      && three_pole_initiate_input |=> retrip_q == 3'h7;
  endproperty
  property p_block_clear;
    ce && block |=> {retrip_q, early_op_q, main_op_q, slow_op_q, zone_trip_output} == 13'h0000;
  endproperty
  property p_path_gate;
    (ce && !early_path_enable |=> early_op_q == 3'h0)
      and (ce && !main_path_enable |=> main_op_q == 3'h0)
      and (ce && !slow_path_enable |=> slow_op_q == 3'h0);
  endproperty
  property p_oos_slow;
    s_oos_held |=> slow_op_q == 3'h0;
  endproperty
  property p_zone_cause;
    s_fail_rise |-> ops_any;
  endproperty
  property p_fail_target;
    s_fail_rise |-> failed_target_q && trip_led_q;
  endproperty
  property p_sup_refuse;
    ce && initiate_current_supervision_enable && cur_low && retrip_q == 3'h0
      |=> retrip_q == 3'h0;
  endproperty
  property p_loset_order;
    loset_active_q[0] |-> hiset_active_q[0];
  endproperty
  property p_single_zone;
    pole_mode_select && ops_any |-> zone_trip_output;
  endproperty

  a_retrip_now: assert property (p_retrip_now)
    else $error("retrip missing after initiate");
  a_block_clear: assert property (p_block_clear)
    else $error("outputs not cleared by block");
  a_path_gate: assert property (p_path_gate)
    else $error("disabled path operated");
  a_oos_slow: assert property (p_oos_slow)
    else $error("slow path ran out of service");
  a_zone_cause: assert property (p_zone_cause)
    else $error("zone trip without path operate");
  a_fail_target: assert property (p_fail_target)
    else $error("target or trip led missing");
  a_sup_refuse: assert property (p_sup_refuse)
    else $error("initiate taken below supervision");
  a_loset_order: assert property (p_loset_order)
    else $error("loset active without hiset");
  a_single_zone: assert property (p_single_zone)
    else $error("single pole operate without zone trip");
endmodule // bfs_checker

bind bfs_scheme bfs_checker u_chk (.*);

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  localparam TC = 4;
  reg         clock, rstn, ce, block, pole_mode_select, seal_in_enable, target_reset;
  reg         initiate_current_supervision_enable, three_pole_initiate_input;
  reg         early_path_enable, main_path_enable, slow_path_enable, out_of_service_input;
  reg  [2:0]  pole_initiate_input;
  reg  [15:0] early_path_delay, main_path_delay, slow_path_delay, loset_delay;
  reg  [15:0] zone_trip_hold_time, phase_supervision_threshold, neutral_supervision_threshold;
  reg  [15:0] phase_hiset_threshold, neutral_hiset_threshold, fault_level;
  reg  [15:0] phase_loset_threshold, neutral_loset_threshold;
  reg  [1:0]  bmode;
  wire [15:0] mag, phase_a_magnitude, phase_b_magnitude, phase_c_magnitude, neutral_magnitude;
  wire [2:0]  aux, early_aux_contact_input, normal_aux_contact_input, retrip_q, initiated_q;
  wire [2:0]  early_op_q, main_op_q, slow_op_q, hiset_active_q, loset_active_q, phase_led_q;
  wire        zone_trip_output, failed_target_q, trip_led_q;
  integer     seed, bad_count, n_checks, i, k;
  logic [8:0] exp_q[$];
  reg         zone_seen;

  bfs_scheme #(.TICK_CYCLES(TC)) u_dut (.*);
  bfs_breaker u_brk (.clock(clock), .trip(|retrip_q), .mode(bmode), .level(fault_level),
                     .aux(aux), .mag(mag));
  // One breaker feeds both contact kinds and every current channel
  assign early_aux_contact_input = aux;
  assign normal_aux_contact_input = aux;
  assign {phase_a_magnitude, phase_b_magnitude} = {mag, mag};
  assign {phase_c_magnitude, neutral_magnitude} = {mag, mag};

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task chk(input [31:0] seen, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task end_sim;
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask

  // Fault level kept well above hiset so current paths see it
  function [15:0] rnd();
    integer r;
    r = $random(seed);
    rnd = 16'h012C + {6'h00, r[9:0]};
  endfunction

  // Let the breaker clear, time the hold, then reset the targets
  task settle;
  begin
    bmode = 2'h0;
    if (zone_trip_output === 1'b1)
    begin
      for (k = 0; k < 200 && {early_op_q, main_op_q, slow_op_q} !== 9'h000; k = k + 1)
        cyc(1);
      for (k = 0; k < 200 && zone_trip_output !== 1'b0; k = k + 1)
        cyc(1);
      chk(k >= (zone_trip_hold_time - 1) * TC && k <= (zone_trip_hold_time + 1) * TC + 6, 1);
    end
    three_pole_initiate_input = 1'b0;
    pole_initiate_input = 3'h0;
    target_reset = 1'b1;
    cyc(1);
    target_reset = 1'b0;
    cyc(4);
    chk({zone_trip_output, failed_target_q, trip_led_q, phase_led_q}, 0);
  end
  endtask

  task trip_case(input [1:0] bm, input [2:0] en, input [8:0] exp, input [2:0] pole,
                 input [15:0] lv);
  begin
    bmode = bm;
    fault_level = lv;
    {early_path_enable, main_path_enable, slow_path_enable} = en;
    if (exp != 9'h000)
      exp_q.push_back(exp);
    if (pole_mode_select)
      pole_initiate_input = pole;
    else
      three_pole_initiate_input = 1'b1;
    cyc(1);
    chk(|retrip_q, !initiate_current_supervision_enable || lv > 16'h0064);
    for (i = 0; i < 400 && zone_trip_output !== 1'b1; i = i + 1)
      cyc(1);
    chk(zone_trip_output, exp != 9'h000);
    if (exp != 9'h000)
      chk({failed_target_q, trip_led_q, phase_led_q}, {2'h3, pole});
    if (exp[8:3] != 6'h00)
      chk(hiset_active_q != 3'h0, 1);
    settle;
  end
  endtask

  // Each zone trip rise is matched with the oldest expected operate set
  always @(negedge clock)
  begin
    if (rstn && zone_trip_output === 1'b1 && !zone_seen)
      chk({early_op_q, main_op_q, slow_op_q}, exp_q.size() != 0 ? exp_q.pop_front() : 9'h000);
    zone_seen = (zone_trip_output === 1'b1);
  end

  // Hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    #500000;
    bad_count = bad_count + 1;
    end_sim;
  end

  initial
  begin
    seed = 90;
    {bad_count, n_checks, zone_seen, bmode, fault_level} = 0;
    {rstn, block, pole_mode_select, seal_in_enable, target_reset} = 5'h00;
    {initiate_current_supervision_enable, three_pole_initiate_input} = 2'h0;
    {early_path_enable, main_path_enable, slow_path_enable, out_of_service_input} = 4'h0;
    {ce, pole_initiate_input} = 4'h8;
    {early_path_delay, main_path_delay} = {16'h0003, 16'h0005};
    {slow_path_delay, loset_delay, zone_trip_hold_time} = {16'h0008, 16'h0002, 16'h0004};
    {phase_supervision_threshold, neutral_supervision_threshold} = {16'h0064, 16'h0064};
    {phase_hiset_threshold, neutral_hiset_threshold} = {16'h00C8, 16'h00C8};
    {phase_loset_threshold, neutral_loset_threshold} = {16'h0096, 16'h0096};
    cyc(5);
    rstn = 1'b1;
    chk({retrip_q, zone_trip_output, failed_target_q}, 0);
    trip_case(2'h0, 3'h7, 9'h000, 3'h0, rnd());
    trip_case(2'h1, 3'h4, 9'h1C0, 3'h0, rnd());
    trip_case(2'h2, 3'h6, 9'h038, 3'h0, rnd());
    trip_case(2'h1, 3'h1, 9'h007, 3'h0, 16'h0032);
    out_of_service_input = 1'b1;
    trip_case(2'h1, 3'h1, 9'h000, 3'h0, 16'h0032);
    out_of_service_input = 1'b0;
    trip_case(2'h1, 3'h0, 9'h000, 3'h0, rnd());
    initiate_current_supervision_enable = 1'b1;
    trip_case(2'h1, 3'h7, 9'h000, 3'h0, 16'h0032);
    trip_case(2'h1, 3'h2, 9'h038, 3'h0, rnd());
    // Seal holds a released initiate only while current stays high
    seal_in_enable = 1'b1;
    bmode = 2'h1;
    fault_level = rnd();
    three_pole_initiate_input = 1'b1;
    cyc(2);
    three_pole_initiate_input = 1'b0;
    cyc(8);
    chk({retrip_q, initiated_q}, 6'h3F);
    fault_level = 16'h0032;
    cyc(3);
    chk({retrip_q, initiated_q}, 6'h00);
    settle;
    // Block in mid timing clears everything
    {seal_in_enable, initiate_current_supervision_enable} = 2'h0;
    fault_level = rnd();
    three_pole_initiate_input = 1'b1;
    cyc(10);
    block = 1'b1;
    cyc(2);
    chk({retrip_q, main_op_q, zone_trip_output}, 0);
    cyc(40);
    chk(zone_trip_output, 1'b0);
    three_pole_initiate_input = 1'b0;
    cyc(1);
    block = 1'b0;
    settle;
    // Clock enable low freezes a live re-trip even after initiate drops
    three_pole_initiate_input = 1'b1;
    cyc(2);
    {ce, three_pole_initiate_input} = 2'h0;
    cyc(4);
    chk(retrip_q, 3'h7);
    ce = 1'b1;
    cyc(2);
    chk(retrip_q, 3'h0);
    settle;
    pole_mode_select = 1'b1;
    trip_case(2'h1, 3'h2, 9'h010, 3'h2, rnd());
    end_sim;
  end
endmodule // tb
